// >>> hdl/cbsc_pkg.sv
// types and helpers for the socket control block
package cbsc_pkg;
  typedef enum logic [1:0] {IS_IDLE, IS_ADDR, IS_DATA, IS_TURN} cbsc_ini_state_t;
  typedef enum logic [1:0] {TS_IDLE, TS_ACT, TS_TURN} cbsc_tgt_state_t;

  // active-low ready pair both asserted
  function automatic logic cbsc_phase_done(input logic irdy_n, input logic trdy_n);
    cbsc_phase_done = !irdy_n && !trdy_n;
  endfunction : cbsc_phase_done
endpackage : cbsc_pkg

// >>> hdl/cbsc_regs.svh
// constants shared by the socket control block
`ifndef CBSC_REGS_SVH
`define CBSC_REGS_SVH
`define CBSC_CLAIM_TMO    3'h5
`define CBSC_PIN_IDLE     1'h1
`define CBSC_PIN_ACT      1'h0
`define CBSC_SYNC_W       16
`define CBSC_SYNC_RST     16'hffcc
`define CBSC_SENSE_RST    2'h0
`endif

// >>> hdl/cbsc_socket.sv
// one socket slot of the card bus control signalling
`timescale 1ns/100ps
`include "cbsc_regs.svh"
module cbsc_socket
  import cbsc_pkg::*;
#(
  parameter int unsigned PH_W = 4
) (
  input  wire logic            mclk_in,
  input  wire logic            rst_n_in,
  input  wire logic            socket_bus_clock_in,
  input  wire logic            cycle_frame_n_in,
  output logic                 cycle_frame_n_out,
  output logic                 cycle_frame_oe_out,
  input  wire logic            initiator_ready_n_in,
  output logic                 initiator_ready_n_out,
  output logic                 initiator_ready_oe_out,
  input  wire logic            target_ready_n_in,
  output logic                 target_ready_n_out,
  output logic                 target_ready_oe_out,
  input  wire logic            target_claim_n_in,
  output logic                 target_claim_n_out,
  output logic                 target_claim_oe_out,
  input  wire logic            stop_request_n_in,
  output logic                 stop_request_n_out,
  output logic                 stop_request_oe_out,
  input  wire logic            exclusive_lock_n_in,
  output logic                 exclusive_lock_n_out,
  output logic                 exclusive_lock_oe_out,
  output logic                 parity_error_line_n_out,
  output logic                 parity_error_line_oe_out,
  input  wire logic            bus_request_n_in,
  output logic                 bus_grant_n_out,
  input  wire logic            card_interrupt_n_in,
  input  wire logic            system_error_n_in,
  input  wire logic            status_change_in,
  input  wire logic            card_audio_in,
  input  wire logic            card_detect_first_n_in,
  input  wire logic            card_detect_second_n_in,
  input  wire logic            voltage_sense_first_in,
  input  wire logic            voltage_sense_second_in,
  input  wire logic            ini_req_in,
  input  wire logic [PH_W-1:0] ini_len_in,
  input  wire logic            ini_lock_in,
  output logic                 ini_busy_out,
  output logic                 ini_done_out,
  output logic                 ini_abort_out,
  input  wire logic            tgt_hit_in,
  input  wire logic            tgt_burst_ok_in,
  output logic                 tgt_phase_out,
  input  wire logic            data_par_err_in,
  input  wire logic            special_cycle_in,
  input  wire logic            serr_en_in,
  input  wire logic            zv_mode_in,
  output logic                 zv_active_out,
  output logic                 speaker_out,
  output logic                 card_present_out,
  output logic [1:0]           card_sense_out,
  output logic                 card_irq_out,
  output logic                 status_change_out,
  output logic                 wake_out,
  output logic                 pci_serr_n_out,
  output logic                 lock_held_out
);
  // all socket pins, clock included, pass two flops first
  logic [`CBSC_SYNC_W-1:0] pins_s;
  cbsc_sync #(.W(`CBSC_SYNC_W), .RST_VAL(`CBSC_SYNC_RST)) u_sync (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .async_in ({socket_bus_clock_in, cycle_frame_n_in, initiator_ready_n_in,
                target_ready_n_in, target_claim_n_in, stop_request_n_in,
                exclusive_lock_n_in, bus_request_n_in, card_interrupt_n_in,
                system_error_n_in, status_change_in, card_audio_in,
                card_detect_first_n_in, card_detect_second_n_in,
                voltage_sense_first_in, voltage_sense_second_in}),
    .sync_out (pins_s)
  );

  wire clk_s   = pins_s[15];
  wire frame_s = pins_s[14];
  wire irdy_s  = pins_s[13];
  wire trdy_s  = pins_s[12];
  wire claim_s = pins_s[11];
  wire stop_s  = pins_s[10];
  wire lock_s  = pins_s[9];
  wire req_s   = pins_s[8];
  wire card_interrupt_s  = pins_s[7];
  wire serr_s  = pins_s[6];
  wire stsch_s = pins_s[5];
  wire aud_s   = pins_s[4];
  wire cd1_s   = pins_s[3];
  wire cd2_s   = pins_s[2];
  wire vs1_s   = pins_s[1];
  wire vs2_s   = pins_s[0];

  logic            clk_d_r;
  logic            frame_d_r;
  logic            serr_d_r;
  cbsc_ini_state_t ist_r;
  cbsc_tgt_state_t tst_r;
  logic [PH_W-1:0] rem_r;
  logic [2:0]      tmo_r;
  logic            claimed_r;
  logic            perr_p_r;

  // every bus action happens at a sampled rising socket clock edge
  wire sk_rise   = clk_s && !clk_d_r;
  wire bus_idle  = frame_s && irdy_s;
  wire ini_start = sk_rise && (ist_r == IS_IDLE) && (tst_r == TS_IDLE) && ini_req_in
                   && bus_grant_n_out && bus_idle && !zv_mode_in;
  wire claim_now = claimed_r || !claim_s;
  wire ini_done  = cbsc_phase_done(initiator_ready_n_out, trdy_s) && claim_now;
  wire ini_tmo   = !claim_now && (tmo_r == `CBSC_CLAIM_TMO - 3'h1);
  wire ini_end   = (ini_done && rem_r == {{(PH_W-1){1'b0}}, 1'b1})
                   || (!stop_s && claim_now && (ini_done || cycle_frame_n_out));
  wire tgt_start = sk_rise && (tst_r == TS_IDLE) && (ist_r == IS_IDLE) && !frame_s
                   && frame_d_r && tgt_hit_in && !zv_mode_in;
  wire tgt_done  = cbsc_phase_done(irdy_s, target_ready_n_out);
  wire tgt_last  = tgt_done && frame_s;
  wire perr_hit  = tgt_done && data_par_err_in && !special_cycle_in;
  wire grant_ok  = !req_s && (ist_r == IS_IDLE) && (tst_r == TS_IDLE) && bus_idle
                   && !ini_req_in && !zv_mode_in;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      // same level as the synchroniser's reset, so no false edge after reset
      clk_d_r   <= `CBSC_PIN_IDLE;
      frame_d_r <= `CBSC_PIN_IDLE;
      serr_d_r  <= `CBSC_PIN_IDLE;
    end else begin
      clk_d_r   <= clk_s;
      serr_d_r  <= serr_s;
      if (sk_rise) begin
        frame_d_r <= frame_s;
      end
    end
  end

  // bridge as initiator
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ist_r                  <= IS_IDLE;
      rem_r                  <= '0;
      tmo_r                  <= 3'h0;
      claimed_r              <= 1'h0;
      cycle_frame_n_out      <= `CBSC_PIN_IDLE;
      cycle_frame_oe_out     <= 1'h0;
      initiator_ready_n_out  <= `CBSC_PIN_IDLE;
      initiator_ready_oe_out <= 1'h0;
      exclusive_lock_n_out   <= `CBSC_PIN_IDLE;
      exclusive_lock_oe_out  <= 1'h0;
      ini_done_out           <= 1'h0;
      ini_abort_out          <= 1'h0;
      ini_busy_out           <= 1'h0;
    end else begin
      ini_done_out  <= 1'h0;
      ini_abort_out <= 1'h0;
      ini_busy_out  <= (ist_r != IS_IDLE) || ini_start;
      case (ist_r)
        IS_IDLE: begin
          if (ini_start) begin
            cycle_frame_n_out  <= `CBSC_PIN_ACT;
            cycle_frame_oe_out <= 1'h1;
            rem_r              <= ini_len_in;
            ist_r              <= IS_ADDR;
          end
        end
        IS_ADDR: begin
          if (sk_rise) begin
            initiator_ready_n_out  <= `CBSC_PIN_ACT;
            initiator_ready_oe_out <= 1'h1;
            tmo_r                  <= 3'h0;
            claimed_r              <= 1'h0;
            if (rem_r <= {{(PH_W-1){1'b0}}, 1'b1}) begin
              cycle_frame_n_out <= `CBSC_PIN_IDLE;
            end
            if (ini_lock_in) begin
              exclusive_lock_n_out  <= `CBSC_PIN_ACT;
              exclusive_lock_oe_out <= 1'h1;
            end
            ist_r <= IS_DATA;
          end
        end
        IS_DATA: begin
          if (sk_rise) begin
            claimed_r <= claim_now;
            if (ini_tmo) begin
              cycle_frame_n_out     <= `CBSC_PIN_IDLE;
              initiator_ready_n_out <= `CBSC_PIN_IDLE;
              ini_abort_out         <= 1'h1;
              ist_r                 <= IS_TURN;
            end else if (ini_end) begin
              cycle_frame_n_out     <= `CBSC_PIN_IDLE;
              initiator_ready_n_out <= `CBSC_PIN_IDLE;
              ist_r                 <= IS_TURN;
            end else begin
              if (!claim_now) begin
                tmo_r <= tmo_r + 3'h1;
              end
              if (ini_done) begin
                rem_r <= rem_r - {{(PH_W-1){1'b0}}, 1'b1};
              end
              if ((ini_done && rem_r == {{(PH_W-2){1'b0}}, 2'h2}) || !stop_s) begin
                cycle_frame_n_out <= `CBSC_PIN_IDLE;
              end
            end
          end
        end
        IS_TURN: begin
          if (sk_rise) begin
            cycle_frame_oe_out     <= 1'h0;
            initiator_ready_oe_out <= 1'h0;
            if (!ini_lock_in) begin
              exclusive_lock_n_out  <= `CBSC_PIN_IDLE;
              exclusive_lock_oe_out <= 1'h0;
            end
            ini_done_out <= 1'h1;
            ist_r        <= IS_IDLE;
          end
        end
        default: ist_r <= IS_IDLE;
      endcase
    end
  end

  // bridge as target of a card cycle
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      tst_r               <= TS_IDLE;
      target_claim_n_out  <= `CBSC_PIN_IDLE;
      target_claim_oe_out <= 1'h0;
      target_ready_n_out  <= `CBSC_PIN_IDLE;
      target_ready_oe_out <= 1'h0;
      stop_request_n_out  <= `CBSC_PIN_IDLE;
      stop_request_oe_out <= 1'h0;
      tgt_phase_out       <= 1'h0;
    end else begin
      tgt_phase_out <= 1'h0;
      case (tst_r)
        TS_IDLE: begin
          if (tgt_start) begin
            target_claim_n_out  <= `CBSC_PIN_ACT;
            target_claim_oe_out <= 1'h1;
            target_ready_n_out  <= `CBSC_PIN_ACT;
            target_ready_oe_out <= 1'h1;
            stop_request_oe_out <= 1'h1;
            tst_r               <= TS_ACT;
          end
        end
        TS_ACT: begin
          if (sk_rise) begin
            tgt_phase_out <= tgt_done;
            if (tgt_last || (frame_s && !stop_request_n_out)) begin
              target_claim_n_out <= `CBSC_PIN_IDLE;
              target_ready_n_out <= `CBSC_PIN_IDLE;
              stop_request_n_out <= `CBSC_PIN_IDLE;
              tst_r              <= TS_TURN;
            end else if (tgt_done && !tgt_burst_ok_in) begin
              stop_request_n_out <= `CBSC_PIN_ACT;
              target_ready_n_out <= `CBSC_PIN_IDLE;
            end
          end
        end
        TS_TURN: begin
          if (sk_rise) begin
            target_claim_oe_out <= 1'h0;
            target_ready_oe_out <= 1'h0;
            stop_request_oe_out <= 1'h0;
            tst_r               <= TS_IDLE;
          end
        end
        default: tst_r <= TS_IDLE;
      endcase
    end
  end

  // parity report, grant, card status
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      perr_p_r                 <= 1'h0;
      parity_error_line_n_out  <= `CBSC_PIN_IDLE;
      parity_error_line_oe_out <= 1'h0;
      bus_grant_n_out          <= `CBSC_PIN_IDLE;
      card_present_out         <= 1'h0;
      card_sense_out           <= `CBSC_SENSE_RST;
      pci_serr_n_out           <= `CBSC_PIN_IDLE;
    end else begin
      if (sk_rise) begin
        perr_p_r                 <= (tst_r == TS_ACT) && perr_hit;
        parity_error_line_n_out  <= !perr_p_r;
        parity_error_line_oe_out <= perr_p_r || !parity_error_line_n_out;
        if (grant_ok) begin
          bus_grant_n_out <= `CBSC_PIN_ACT;
        end else if (req_s) begin
          bus_grant_n_out <= `CBSC_PIN_IDLE;
        end
      end
      card_present_out <= !cd1_s && !cd2_s;
      if (!cd1_s && !cd2_s && !card_present_out) begin
        card_sense_out <= {vs2_s, vs1_s};
      end else if (cd1_s || cd2_s) begin
        card_sense_out <= `CBSC_SENSE_RST;
      end
      // only the falling edge reports, so a slow release cannot retrigger
      pci_serr_n_out <= !(serr_en_in && !serr_s && serr_d_r);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      speaker_out       <= 1'h0;
      card_irq_out      <= 1'h0;
      status_change_out <= 1'h0;
      wake_out          <= 1'h0;
      zv_active_out     <= 1'h0;
      lock_held_out     <= 1'h0;
    end else begin
      speaker_out       <= aud_s;
      card_irq_out      <= !card_interrupt_s;
      status_change_out <= stsch_s;
      wake_out          <= stsch_s && !status_change_out;
      zv_active_out     <= zv_mode_in;
      lock_held_out     <= !lock_s && exclusive_lock_n_out;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_tgt_bad_phase;
    sk_rise && (tst_r == TS_ACT) && perr_hit;
  endsequence
  sequence s_perr_shown;
    ##[1:40] (!parity_error_line_n_out && parity_error_line_oe_out);
  endsequence

  a_audio_passes:   assert property (speaker_out == $past(aud_s))
    else $error("speaker does not follow card audio");
  a_detect_decode:  assert property (card_present_out == $past(!cd1_s && !cd2_s))
    else $error("card presence wrong");
  a_target_claims:  assert property ((tst_r == TS_ACT) |-> !target_claim_n_out
                                     && target_claim_oe_out)
    else $error("active target not claiming");
  a_claim_timeout:  assert property ((ist_r == IS_DATA && sk_rise && ini_tmo)
                                     |=> ini_abort_out && cycle_frame_n_out)
    else $error("no abort after claim timeout");
  a_grant_idle:     assert property ($fell(bus_grant_n_out) |-> $past(!req_s && bus_idle
                                     && ist_r == IS_IDLE))
    else $error("grant given while bus busy");
  a_irq_level:      assert property (card_irq_out == $past(!card_interrupt_s))
    else $error("interrupt level not followed");
  a_perr_report:    assert property (s_tgt_bad_phase |-> s_perr_shown)
    else $error("parity error not reported");
  a_no_special:     assert property ((sk_rise && special_cycle_in && tst_r == TS_ACT)
                                     |=> !perr_p_r)
    else $error("special cycle produced parity report");
  a_serr_forward:   assert property ((serr_en_in && $fell(serr_s)) |=> !pci_serr_n_out)
    else $error("card system error not forwarded");
  a_frame_start:    assert property (ini_start |=> !cycle_frame_n_out
                                     && cycle_frame_oe_out)
    else $error("frame not asserted at start");
endmodule : cbsc_socket

// >>> hdl/cbsc_sync.sv
// two flip-flop synchroniser for socket pins
`timescale 1ns/100ps
module cbsc_sync #(
  parameter int unsigned      W       = 1,
  parameter logic [W-1:0]     RST_VAL = '0
) (
  input  wire logic           mclk_in,
  input  wire logic           rst_n_in,
  input  wire logic [W-1:0]   async_in,
  output logic      [W-1:0]   sync_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      meta_r   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : cbsc_sync

// >>> test/cbsc_card_model.sv
// card-side partner model: answers bridge cycles and runs its own as initiator
`timescale 1ns/100ps
module cbsc_card_model (
  input  wire logic       sclk_in,
  input  wire logic [5:0] w_in,
  input  wire logic       grant_n_in,
  input  wire logic       tgt_en_in,
  input  wire logic [1:0] wait_in,
  input  wire logic       go_in,
  input  wire logic [3:0] len_in,
  output logic      [5:0] c_n_out,
  output logic      [5:0] c_oe_out,
  output logic            req_n_out,
  output logic      [3:0] t_cnt_out
);
  // pin order: frame irdy trdy claim stop lock
  logic       t_act_r, i_act_r, used_r;
  logic [1:0] wt_r, nw;
  logic [2:0] ab_r;
  logic [3:0] rem_r;
  logic [5:0] cn_r, coe_r;
  wire        done = !w_in[1] && !w_in[2];
  assign req_n_out = !(go_in && !used_r);
  initial begin
    c_n_out = '1;
    c_oe_out = '0;
    cn_r = '1;
    coe_r = '0;
    t_cnt_out = '0;
    rem_r = '0;
    wt_r = '0;
    ab_r = '0;
    t_act_r = 0;
    i_act_r = 0;
    used_r = 0;
  end
  // pins change half a clock after the edge, clear of the bridge's sampling
  always @(negedge sclk_in) begin
    c_n_out <= cn_r;
    c_oe_out <= coe_r;
  end
  always @(posedge sclk_in) begin
    nw = done ? wait_in : (wt_r == 2'h0 ? 2'h0 : wt_r - 2'h1);
    if (!go_in) used_r <= 0;
    if (!i_act_r && !t_act_r && !w_in[0] && tgt_en_in) begin
      t_act_r <= 1;
      t_cnt_out <= '0;
      wt_r <= wait_in;
      coe_r[3:2] <= 2'h3;
      cn_r[3:2] <= {1'b0, wait_in != 2'h0};
    end else if (t_act_r) begin
      wt_r <= nw;
      cn_r[2] <= nw != 2'h0;
      if (done) t_cnt_out <= t_cnt_out + 4'h1;
      if (done && w_in[0]) begin
        t_act_r <= 0;
        coe_r[3:2] <= 2'h0;
        cn_r[3:2] <= 2'h3;
      end
    end
    if (!i_act_r && !used_r && go_in && !grant_n_in && w_in[0] && w_in[1]) begin
      i_act_r <= 1;
      used_r <= 1;
      rem_r <= len_in;
      ab_r <= 3'h0;
      coe_r[1:0] <= 2'h3;
      cn_r[1:0] <= 2'h2;
    end else if (i_act_r) begin
      cn_r[1] <= 0;
      // unclaimed cycle: give up after a few edges
      ab_r <= w_in[3] ? ab_r + 3'h1 : 3'h0;
      if (done) rem_r <= rem_r - 4'h1;
      if (rem_r - 4'(done) <= 4'h1 || !w_in[4]) cn_r[0] <= 1;
      if ((w_in[0] && (done || !w_in[4])) || ab_r == 3'h4) begin
        i_act_r <= 0;
        coe_r[1:0] <= 2'h0;
        cn_r[1:0] <= 2'h3;
      end
    end
  end
endmodule : cbsc_card_model

// >>> test/cbsc_socket_bench.sv
// testbench for one socket slot of the card bus control block
`timescale 1ns/100ps
module cbsc_socket_bench;
  logic mclk_in, rst_n_in, socket_bus_clock_in, cycle_frame_n_in, initiator_ready_n_in;
  logic target_ready_n_in, target_claim_n_in, stop_request_n_in, exclusive_lock_n_in;
  logic bus_request_n_in, card_interrupt_n_in, system_error_n_in, status_change_in;
  logic card_audio_in, card_detect_first_n_in, card_detect_second_n_in;
  logic voltage_sense_first_in, voltage_sense_second_in, ini_req_in, ini_lock_in;
  logic tgt_hit_in, tgt_burst_ok_in, data_par_err_in, special_cycle_in, serr_en_in, zv_mode_in;
  logic cycle_frame_n_out, cycle_frame_oe_out, initiator_ready_n_out, initiator_ready_oe_out;
  logic target_ready_n_out, target_ready_oe_out, target_claim_n_out, target_claim_oe_out;
  logic stop_request_n_out, stop_request_oe_out, exclusive_lock_n_out, exclusive_lock_oe_out;
  logic parity_error_line_n_out, parity_error_line_oe_out, bus_grant_n_out, ini_busy_out;
  logic ini_done_out, ini_abort_out, tgt_phase_out, zv_active_out, speaker_out;
  logic card_present_out, card_irq_out, status_change_out, wake_out, pci_serr_n_out;
  logic lock_held_out, m_go, m_tgt_en, gnt_p, perr_p, cl_p;
  logic [1:0] card_sense_out, m_wait;
  logic [3:0] ini_len_in, m_len, t_cnt;
  logic [5:0] b_n, b_oe, c_n, c_oe, w;
  logic [7:0] sk_cnt, ph_sk;
  logic [7:0] ev_q[$];
  int         n_fail, n_tests, cyc_cnt;
  wire        perr_lo = parity_error_line_oe_out && !parity_error_line_n_out;

  cbsc_socket #(.PH_W(4)) dut (.*);
  cbsc_card_model card (.sclk_in(socket_bus_clock_in), .w_in(w), .grant_n_in(bus_grant_n_out),
    .tgt_en_in(m_tgt_en), .wait_in(m_wait), .go_in(m_go), .len_in(m_len), .c_n_out(c_n),
    .c_oe_out(c_oe), .req_n_out(bus_request_n_in), .t_cnt_out(t_cnt));

  assign b_n = {exclusive_lock_n_out, stop_request_n_out, target_claim_n_out,
                target_ready_n_out, initiator_ready_n_out, cycle_frame_n_out};
  assign b_oe = {exclusive_lock_oe_out, stop_request_oe_out, target_claim_oe_out,
                 target_ready_oe_out, initiator_ready_oe_out, cycle_frame_oe_out};
  // released pins are pulled high
  assign w = (b_oe & b_n) | (~b_oe & c_oe & c_n) | (~b_oe & ~c_oe);
  assign {exclusive_lock_n_in, stop_request_n_in, target_claim_n_in, target_ready_n_in,
          initiator_ready_n_in, cycle_frame_n_in} = w;

  always #20 mclk_in = ~mclk_in;
  initial begin
    socket_bus_clock_in = 0;
    #17;
    forever #160 socket_bus_clock_in = ~socket_bus_clock_in;
  end

  task automatic chk_val(input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t value exp %h got %h", $time, exp, got);
    end
  endtask : chk_val

  task automatic chk_ev(input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t event exp %h got %h", $time, exp, got);
    end
  endtask : chk_ev

  task automatic pop(input logic [7:0] got);
    chk_ev(ev_q.size() != 0 ? ev_q.pop_front() : 8'hff, got);
  endtask : pop

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : cyc

  task automatic drain;
    for (int i = 0; i < 3000 && ev_q.size() != 0; i++) @(posedge mclk_in);
    chk_val(8'h0, 8'(ev_q.size()));
  endtask : drain

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic host_xfer(input logic [3:0] len, input logic en, input logic [1:0] wt,
                           input logic also);
    m_tgt_en <= en;
    m_wait <= wt;
    ini_len_in <= len;
    ini_req_in <= 1;
    if (!en) ev_q.push_back(8'h2);
    ev_q.push_back(8'h1);
    for (int i = 0; i < 400 && ini_busy_out !== 1'b1; i++) @(posedge mclk_in);
    ini_req_in <= 0;
    if (also) m_go <= 1;
    if (also) ev_q.push_back(8'h3);
    drain();
    m_go <= 0;
    if (en) chk_val({4'h0, len}, {4'h0, t_cnt});
    cyc(10);
  endtask : host_xfer

  task automatic card_xfer(input logic [3:0] len, input logic pe, input logic sp,
                           input logic bo);
    data_par_err_in <= pe;
    special_cycle_in <= sp;
    tgt_burst_ok_in <= bo;
    m_len <= len;
    m_go <= 1;
    for (int i = 0; i < (bo ? int'(len) : 1); i++) ev_q.push_back(8'h3);
    if (pe && !sp) ev_q.push_back(8'h4);
    drain();
    m_go <= 0;
    cyc(20);
  endtask : card_xfer

  always @(posedge socket_bus_clock_in) sk_cnt <= sk_cnt + 8'h1;

  always @(posedge mclk_in) begin
    gnt_p <= bus_grant_n_out;
    perr_p <= perr_lo;
    cl_p <= target_claim_n_out;
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 60000) begin
      n_fail++;
      test_done();
    end
    if (rst_n_in) begin
      if (gnt_p && !bus_grant_n_out) chk_val(8'h0, {7'h0, ini_busy_out});
      if (ini_done_out) pop(8'h1);
      if (ini_abort_out) pop(8'h2);
      if (tgt_phase_out) begin
        pop(8'h3);
        chk_val(8'h0, {7'h0, cl_p});
        ph_sk <= sk_cnt;
      end
      if (perr_lo && !perr_p) begin
        pop(8'h4);
        chk_val(8'h1, sk_cnt - ph_sk);
      end
      if (!pci_serr_n_out) pop(8'h5);
      if (wake_out) pop(8'h6);
    end
  end

  initial begin
    mclk_in = 0;
    rst_n_in = 0;
    {status_change_in, card_audio_in, voltage_sense_first_in, voltage_sense_second_in} = '0;
    {ini_req_in, ini_lock_in, data_par_err_in, special_cycle_in, zv_mode_in, m_go} = '0;
    {card_detect_first_n_in, card_detect_second_n_in, card_interrupt_n_in} = '1;
    {system_error_n_in, tgt_hit_in, tgt_burst_ok_in, serr_en_in, m_tgt_en} = '1;
    ini_len_in = 4'h1;
    m_len = 4'h1;
    m_wait = 2'h0;
    {n_fail, n_tests, cyc_cnt} = '0;
    {sk_cnt, ph_sk} = '0;
    {gnt_p, perr_p, cl_p} = 3'h5;
    void'($urandom(32'h423a));
    cyc(4);
    chk_val(8'h3f, {2'h0, b_n});
    chk_val(8'h0, {2'h0, b_oe});
    cyc(1);
    rst_n_in <= 1;
    cyc(4);
    for (int i = 0; i < 4; i++) begin
      card_audio_in <= 1'($urandom);
      cyc(6);
      chk_val({7'h0, card_audio_in}, {7'h0, speaker_out});
    end
    {voltage_sense_second_in, voltage_sense_first_in} <= 2'($urandom);
    card_detect_first_n_in <= 0;
    cyc(8);
    chk_val(8'h0, {7'h0, card_present_out});
    card_detect_second_n_in <= 0;
    cyc(8);
    chk_val(8'h1, {7'h0, card_present_out});
    chk_val({6'h0, voltage_sense_second_in, voltage_sense_first_in},
            {6'h0, card_sense_out});
    card_interrupt_n_in <= 0;
    cyc(6);
    chk_val(8'h1, {7'h0, card_irq_out});
    card_interrupt_n_in <= 1;
    cyc(6);
    chk_val(8'h0, {7'h0, card_irq_out});
    ev_q.push_back(8'h6);
    status_change_in <= 1;
    cyc(6);
    chk_val(8'h1, {7'h0, status_change_out});
    drain();
    status_change_in <= 0;
    ev_q.push_back(8'h5);
    system_error_n_in <= 0;
    cyc(40);
    system_error_n_in <= 1;
    drain();
    serr_en_in <= 0;
    system_error_n_in <= 0;
    cyc(20);
    system_error_n_in <= 1;
    cyc(20);
    zv_mode_in <= 1;
    ini_req_in <= 1;
    cyc(40);
    chk_val(8'h1, {7'h0, zv_active_out});
    chk_val(8'h0, {7'h0, ini_busy_out});
    zv_mode_in <= 0;
    host_xfer(4'h2, 1'b1, 2'h1, 1'b0);
    for (int i = 0; i < 4; i++) host_xfer(4'($urandom_range(1, 4)), 1'b1,
                                          2'($urandom_range(0, 2)), 1'b0);
    host_xfer(4'h1, 1'b0, 2'h0, 1'b0);
    ini_lock_in <= 1;
    host_xfer(4'h2, 1'b1, 2'h0, 1'b0);
    chk_val(8'h0, {7'h0, w[5]});
    chk_val(8'h0, {7'h0, lock_held_out});
    ini_lock_in <= 0;
    host_xfer(4'h1, 1'b1, 2'h0, 1'b0);
    chk_val(8'h1, {7'h0, w[5]});
    host_xfer(4'h4, 1'b1, 2'h2, 1'b1);
    card_xfer(4'($urandom_range(2, 4)), 1'b0, 1'b0, 1'b1);
    card_xfer(4'h1, 1'b1, 1'b0, 1'b1);
    card_xfer(4'h1, 1'b1, 1'b1, 1'b1);
    card_xfer(4'h3, 1'b0, 1'b0, 1'b0);
    // card cycle with no hit: no claim, no target phase may appear
    tgt_hit_in <= 0;
    m_len <= 4'h1;
    m_go <= 1;
    cyc(160);
    m_go <= 0;
    tgt_hit_in <= 1;
    cyc(20);
    chk_val(8'h0, {7'h0, target_claim_oe_out});
    test_done();
  end
endmodule : cbsc_socket_bench
